// *** sbt_defines.svh ***
// Constants of the boundary-scan test port: instruction codes, scan lengths,
// identification fields and timing figures.
// Assumes inclusion by bare name from every file that uses these macros.
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// Instruction register width and codes.
`define SBT_IR_WIDTH        3
`define SBT_IR_EXTEST       3'h0
`define SBT_IR_IDCODE       3'h1
`define SBT_IR_SAMPLE_Z     3'h2
`define SBT_IR_SAMPLE       3'h4
`define SBT_IR_BYPASS       3'h7
// Capture pattern of the instruction register: low two bits, then the top bit.
`define SBT_IR_CAPTURE_LO   2'h1
`define SBT_IR_CAPTURE_HI   1'h0

// Boundary chain lengths of the two widths.
`define SBT_BSR_LEN_X36     73
`define SBT_BSR_LEN_X18     54

// Identification word fields, most significant first.
`define SBT_ID_WIDTH        32
`define SBT_ID_REV          3'h0
`define SBT_ID_DEPTH        5'h0B
`define SBT_ID_ARCH         6'h00
`define SBT_ID_BUS_X36      6'h24
`define SBT_ID_BUS_X18      6'h14
`define SBT_ID_PRESENT      1'h1

// Bypass capture value, reset depth of the port and fastest test clock.
`define SBT_BYPASS_CAPTURE  1'h0
`define SBT_TAP_RESET_EDGES 5
`define SBT_TCK_MAX_MHZ     10

`endif

// *** sbt_pkg.sv ***
// Types of the boundary-scan test port.
// Assumes nothing of its surroundings.
`default_nettype none
package sbt_pkg;

  // The sixteen states of the test port controller.
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } sbt_tap_state_t;

  // Data register placed between serial in and serial out.
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_ID, SEL_BSR
  } sbt_dr_sel_t;

endpackage : sbt_pkg
`default_nettype wire

// *** sbt_sync2.sv ***
// Two-flop synchroniser for levels entering a clock domain.
// Assumes each bit is a level that may change at any time.
`default_nettype none
module sbt_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Level in and synchronised level out.
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : sbt_sync2
`default_nettype wire

// *** sbt_bsr.sv ***
// Boundary scan register: one cell per ring ball, capture and shift only.
// Assumes capture and shift strobes come from the test port controller.
`default_nettype none
module sbt_bsr #(
  parameter int unsigned LEN = 73
) (
  // Test clock and reset.
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // Controller strobes.
  input  wire logic           capture_i,
  input  wire logic           shift_i,
  // Serial and parallel data.
  input  wire logic           si_i,
  input  wire logic [LEN-1:0] ring_i,
  output logic                so_o
);

  logic [LEN-1:0] cell_q;
  logic [LEN:0]   chain;

  // The serial input enters the top cell.
  assign chain[LEN] = si_i;
  assign so_o       = cell_q[0];

  // Each cell captures its ball, shifts toward bit zero, else holds.
  for (genvar i = 0; i < LEN; i++)
  begin : g_cell
    assign chain[i] = cell_q[i];
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        cell_q[i] <= 1'h0;
      else if (capture_i)
        cell_q[i] <= ring_i[i];
      else if (shift_i)
        cell_q[i] <= chain[i+1];
    end
  end

endmodule : sbt_bsr
`default_nettype wire

// *** sbt_tap.sv ***
// Boundary-scan test port of a synchronous memory: controller, instruction
// register, boundary chain, identification and bypass registers.
// Assumes tms and tdi are stable around the rising test clock edge, ring
// balls arrive asynchronously, and the memory clock is ref_clk_i.
`include "sbt_defines.svh"
`default_nettype none
module sbt_tap #(
  parameter int unsigned BSR_LEN   = `SBT_BSR_LEN_X36,
  // Vendor field of the identification word; the value is arbitrary.
  parameter logic [10:0] VENDOR_ID = 11'h2A5
) (
  // Memory clock and power-up reset.
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Test port from the scan controller.
  input  wire logic               tck_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  // Ring balls observed by the boundary chain.
  input  wire logic [BSR_LEN-1:0] ring_i,
  // Request to float all memory output drivers.
  output logic                    float_outputs_o
);

  // Identification word, assembled from its fields.
  localparam logic [5:0] ID_BUS = (BSR_LEN == `SBT_BSR_LEN_X18) ?
                                  `SBT_ID_BUS_X18 : `SBT_ID_BUS_X36;
  localparam logic [`SBT_ID_WIDTH-1:0] ID_WORD = {
    `SBT_ID_REV, `SBT_ID_DEPTH, `SBT_ID_ARCH, ID_BUS, VENDOR_ID,
    `SBT_ID_PRESENT};

  sbt_pkg::sbt_tap_state_t        state_q;
  sbt_pkg::sbt_tap_state_t        state_d;
  sbt_pkg::sbt_dr_sel_t           dr_sel;
  logic                           tck_rst_n;
  logic [BSR_LEN-1:0]             ring_sync;
  logic [`SBT_IR_WIDTH-1:0]       ir_q;
  logic [`SBT_IR_WIDTH-1:0]       ir_sh_q;
  logic [`SBT_ID_WIDTH-1:0]       id_sh_q;
  logic                           byp_q;
  logic                           bsr_so;
  logic                           bsr_cap;
  logic                           bsr_shift;
  logic                           float_req_q;
  logic                           tdo_d;

  // Power-up reset, released in step with the test clock.
  sbt_sync2 #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_n_i),
    .d_i     (1'h1),
    .q_o     (tck_rst_n)
  );

  // Ring balls cross into the test clock domain before capture.
  sbt_sync2 #(
    .WIDTH (BSR_LEN)
  ) u_ring_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_n_i),
    .d_i     (ring_i),
    .q_o     (ring_sync)
  );

  // Controller next state from the mode select sampled at the rising edge.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sbt_pkg::TAP_TLR:      state_d = tms_i ? sbt_pkg::TAP_TLR    : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_RTI:      state_d = tms_i ? sbt_pkg::TAP_SEL_DR : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_SEL_DR:   state_d = tms_i ? sbt_pkg::TAP_SEL_IR : sbt_pkg::TAP_CAP_DR;
      sbt_pkg::TAP_CAP_DR:   state_d = tms_i ? sbt_pkg::TAP_EX1_DR : sbt_pkg::TAP_SH_DR;
      sbt_pkg::TAP_SH_DR:    state_d = tms_i ? sbt_pkg::TAP_EX1_DR : sbt_pkg::TAP_SH_DR;
      sbt_pkg::TAP_EX1_DR:   state_d = tms_i ? sbt_pkg::TAP_UPD_DR : sbt_pkg::TAP_PAUSE_DR;
      sbt_pkg::TAP_PAUSE_DR: state_d = tms_i ? sbt_pkg::TAP_EX2_DR : sbt_pkg::TAP_PAUSE_DR;
      sbt_pkg::TAP_EX2_DR:   state_d = tms_i ? sbt_pkg::TAP_UPD_DR : sbt_pkg::TAP_SH_DR;
      sbt_pkg::TAP_UPD_DR:   state_d = tms_i ? sbt_pkg::TAP_SEL_DR : sbt_pkg::TAP_RTI;
      sbt_pkg::TAP_SEL_IR:   state_d = tms_i ? sbt_pkg::TAP_TLR    : sbt_pkg::TAP_CAP_IR;
      sbt_pkg::TAP_CAP_IR:   state_d = tms_i ? sbt_pkg::TAP_EX1_IR : sbt_pkg::TAP_SH_IR;
      sbt_pkg::TAP_SH_IR:    state_d = tms_i ? sbt_pkg::TAP_EX1_IR : sbt_pkg::TAP_SH_IR;
      sbt_pkg::TAP_EX1_IR:   state_d = tms_i ? sbt_pkg::TAP_UPD_IR : sbt_pkg::TAP_PAUSE_IR;
      sbt_pkg::TAP_PAUSE_IR: state_d = tms_i ? sbt_pkg::TAP_EX2_IR : sbt_pkg::TAP_PAUSE_IR;
      sbt_pkg::TAP_EX2_IR:   state_d = tms_i ? sbt_pkg::TAP_UPD_IR : sbt_pkg::TAP_SH_IR;
      sbt_pkg::TAP_UPD_IR:   state_d = tms_i ? sbt_pkg::TAP_SEL_DR : sbt_pkg::TAP_RTI;
      default:               state_d = sbt_pkg::TAP_TLR;
    endcase
  end

  // Controller state; mode select high from any state reaches reset in five.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      state_q <= sbt_pkg::TAP_TLR;
    else
      state_q <= state_d;
  end

  // Instruction shift stage: capture the fixed pattern, shift from the top.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      ir_sh_q <= `SBT_IR_IDCODE;
    else if (state_q == sbt_pkg::TAP_CAP_IR)
      ir_sh_q <= {`SBT_IR_CAPTURE_HI, `SBT_IR_CAPTURE_LO};
    else if (state_q == sbt_pkg::TAP_SH_IR)
      ir_sh_q <= {tdi_i, ir_sh_q[`SBT_IR_WIDTH-1:1]};
  end

  // Active instruction: identification after reset, else taken at update.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      ir_q <= `SBT_IR_IDCODE;
    else if (state_q == sbt_pkg::TAP_TLR)
      ir_q <= `SBT_IR_IDCODE;
    else if (state_q == sbt_pkg::TAP_UPD_IR)
      ir_q <= ir_sh_q;
  end

  // Decode the active instruction; reserved codes fall back to bypass.
  always_comb
  begin
    case (ir_q)
      `SBT_IR_EXTEST:   dr_sel = sbt_pkg::SEL_BSR;
      `SBT_IR_IDCODE:   dr_sel = sbt_pkg::SEL_ID;
      `SBT_IR_SAMPLE_Z: dr_sel = sbt_pkg::SEL_BSR;
      `SBT_IR_SAMPLE:   dr_sel = sbt_pkg::SEL_BSR;
      `SBT_IR_BYPASS:   dr_sel = sbt_pkg::SEL_BYPASS;
      default:          dr_sel = sbt_pkg::SEL_BYPASS;
    endcase
  end

  // Boundary chain strobes; update and pause both leave it untouched.
  assign bsr_cap   = (state_q == sbt_pkg::TAP_CAP_DR) &&
                     (dr_sel == sbt_pkg::SEL_BSR);
  assign bsr_shift = (state_q == sbt_pkg::TAP_SH_DR) &&
                     (dr_sel == sbt_pkg::SEL_BSR);

  // Boundary chain of one cell per observed ball, capture and shift only.
  sbt_bsr #(
    .LEN (BSR_LEN)
  ) u_bsr (
    .clk_i     (tck_i),
    .rst_n_i   (tck_rst_n),
    .capture_i (bsr_cap),
    .shift_i   (bsr_shift),
    .si_i      (tdi_i),
    .ring_i    (ring_sync),
    .so_o      (bsr_so)
  );

  // Identification register: fixed word at capture, shift from the top.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      id_sh_q <= '0;
    else if ((state_q == sbt_pkg::TAP_CAP_DR) && (dr_sel == sbt_pkg::SEL_ID))
      id_sh_q <= ID_WORD;
    else if ((state_q == sbt_pkg::TAP_SH_DR) && (dr_sel == sbt_pkg::SEL_ID))
      id_sh_q <= {tdi_i, id_sh_q[`SBT_ID_WIDTH-1:1]};
  end

  // Bypass bit: cleared at capture, one stage of delay in shift.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      byp_q <= `SBT_BYPASS_CAPTURE;
    else if ((state_q == sbt_pkg::TAP_CAP_DR) && (dr_sel == sbt_pkg::SEL_BYPASS))
      byp_q <= `SBT_BYPASS_CAPTURE;
    else if ((state_q == sbt_pkg::TAP_SH_DR) && (dr_sel == sbt_pkg::SEL_BYPASS))
      byp_q <= tdi_i;
  end

  // Serial output source: bit zero of whichever register is in the path.
  always_comb
  begin
    tdo_d = 1'h0;
    if (state_q == sbt_pkg::TAP_SH_IR)
      tdo_d = ir_sh_q[0];
    else if (state_q == sbt_pkg::TAP_SH_DR)
    begin
      case (dr_sel)
        sbt_pkg::SEL_ID:  tdo_d = id_sh_q[0];
        sbt_pkg::SEL_BSR: tdo_d = bsr_so;
        default:          tdo_d = byp_q;
      endcase
    end
  end

  // Serial output and its enable change on the falling edge, or at once on reset.
  always_ff @(negedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
    begin
      tdo_o    <= 1'h0;
      tdo_oe_o <= 1'h0;
    end
    else
    begin
      tdo_o    <= tdo_d;
      tdo_oe_o <= (state_q == sbt_pkg::TAP_SH_IR) ||
                  (state_q == sbt_pkg::TAP_SH_DR);
    end
  end

  // Float request held while the all-zero or float-sample code is active.
  // It changes at the same edge as the instruction, because the controller
  // may stop the test clock right after update.
  always_ff @(posedge tck_i or negedge tck_rst_n)
  begin
    if (!tck_rst_n)
      float_req_q <= 1'h0;
    else if (state_q == sbt_pkg::TAP_TLR)
      float_req_q <= 1'h0;
    else if (state_q == sbt_pkg::TAP_UPD_IR)
      float_req_q <= (ir_sh_q == `SBT_IR_EXTEST) ||
                     (ir_sh_q == `SBT_IR_SAMPLE_Z);
  end

  // The float request crosses to the memory clock as a level.
  sbt_sync2 #(
    .WIDTH (1)
  ) u_float_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (float_req_q),
    .q_o     (float_outputs_o)
  );

  // Checks in the test clock domain.
  default clocking cb @(posedge tck_i);
  endclocking
  default disable iff (!tck_rst_n);

  property p_ir_reset;
    (state_q == sbt_pkg::TAP_TLR) |=> (ir_q == `SBT_IR_IDCODE);
  endproperty
  a_ir_reset: assert property (p_ir_reset)
    else $error("Instruction not identification after idle-reset.");

  property p_ir_capture;
    (state_q == sbt_pkg::TAP_CAP_IR) |=> (ir_sh_q[1:0] == `SBT_IR_CAPTURE_LO);
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("Instruction capture pattern wrong.");

  property p_ir_update_only;
    !$stable(ir_q) |-> ($past(state_q) == sbt_pkg::TAP_UPD_IR) ||
                       ($past(state_q) == sbt_pkg::TAP_TLR);
  endproperty
  a_ir_update_only: assert property (p_ir_update_only)
    else $error("Instruction changed outside update.");

  property p_id_capture;
    (state_q == sbt_pkg::TAP_CAP_DR) && (ir_q == `SBT_IR_IDCODE)
      |=> (id_sh_q == ID_WORD);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("Identification word not captured.");

  property p_id_shift;
    (state_q == sbt_pkg::TAP_SH_DR) && (ir_q == `SBT_IR_IDCODE)
      |-> (tdo_o == id_sh_q[0]) ##1 (id_sh_q[`SBT_ID_WIDTH-1] == $past(tdi_i));
  endproperty
  a_id_shift: assert property (p_id_shift)
    else $error("Identification shift path wrong.");

  property p_bypass;
    (state_q == sbt_pkg::TAP_SH_DR) && (ir_q == `SBT_IR_BYPASS)
      |=> (byp_q == $past(tdi_i));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypass bit did not take serial input.");

  property p_tap_reset;
    tms_i [*5] |=> (state_q == sbt_pkg::TAP_TLR);
  endproperty
  a_tap_reset: assert property (p_tap_reset)
    else $error("Five high mode edges did not reset the port.");

  property p_tdo_float;
    tdo_oe_o == ((state_q == sbt_pkg::TAP_SH_IR) || (state_q == sbt_pkg::TAP_SH_DR));
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("Serial output enable outside shift states.");

  property p_float_out;
    float_req_q [*3] |-> float_outputs_o;
  endproperty
  a_float_out: assert property (p_float_out)
    else $error("Memory outputs not floated.");

  property p_sample_update;
    (state_q == sbt_pkg::TAP_UPD_DR) |=> $stable(bsr_so);
  endproperty
  a_sample_update: assert property (p_sample_update)
    else $error("Boundary chain changed at update.");

  property p_float_req;
    float_req_q == ((ir_q == `SBT_IR_EXTEST) || (ir_q == `SBT_IR_SAMPLE_Z));
  endproperty
  a_float_req: assert property (p_float_req)
    else $error("Float request does not follow the instruction.");

  property p_bsr_capture;
    bsr_cap |=> (bsr_so == $past(ring_sync[0]));
  endproperty
  a_bsr_capture: assert property (p_bsr_capture)
    else $error("Boundary chain did not capture the ring.");

  property p_ir_tdo;
    (state_q == sbt_pkg::TAP_SH_IR) |-> (tdo_o == ir_sh_q[0]);
  endproperty
  a_ir_tdo: assert property (p_ir_tdo)
    else $error("Instruction shift output wrong.");

  // Main scenarios.
  c_id_shift: cover property ((state_q == sbt_pkg::TAP_SH_DR) && (ir_q == `SBT_IR_IDCODE));
  c_bypass:   cover property ((state_q == sbt_pkg::TAP_SH_DR) && (ir_q == `SBT_IR_BYPASS));
  c_bsr_cap:  cover property (bsr_cap ##1 bsr_shift);
  c_float:    cover property ($rose(float_req_q));

endmodule : sbt_tap
`default_nettype wire

// *** sbt_scan_model.sv ***
// Behavioural scan controller that drives the test port of the memory.
// Assumes the bench calls one task at a time and nothing else drives the port.
`default_nettype none
module sbt_scan_model (
  // Test port lines.
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bad_cnt;
  logic       oe_after;
  logic [1:0] dmy;

  // The clock rests low and the pulled-up lines start high; tms rests low between frames.
  initial
  begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b1;
    bad_cnt  = 0;
    oe_after = 1'b0;
  end

  // One 100 ns period: lines move after the fall, tdo is read around the rise.
  // A released tdo has no pull, so the model sees the inverse of its level.
  task automatic step(input logic tms, input logic tdi, output logic pre, output logic oe);
    logic post;
    tms_o <= tms;
    tdi_o <= tdi;
    #25;
    oe  = tdo_oe_i;
    pre = oe ? tdo_i : ~tdo_i;
    #25 tck_o = 1'b1;
    #5 post = tdo_oe_i ? tdo_i : ~tdo_i;
    if (post !== pre)
      bad_cnt++;
    #45 tck_o = 1'b0;
  endtask : step

  // Walks the controller with the given mode bits, first bit first.
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b1, dmy[0], dmy[1]);
  endtask : walk

  // Shifts n bits, least significant first, then takes one more step.
  task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout,
                       input logic nxt);
    logic oe;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], dout[i], oe);
      if (oe !== 1'b1)
        bad_cnt++;
    end
    step(nxt, 1'b1, dmy[0], oe_after);
  endtask : shift

  // Five rises with mode high, then back to idle.
  task automatic reset_port();
    walk(8'h1F, 6);
  endtask : reset_port

  // Shifts in an instruction and stops in the pause state before update.
  task automatic scan_ir(input logic [2:0] code, output logic [2:0] cap);
    logic [127:0] o;
    walk(8'h03, 4);
    shift(3, 128'(code), o, 1'b0);
    cap = o[2:0];
  endtask : scan_ir

  // Leaves the pause state through update so the new instruction acts.
  task automatic finish_ir();
    walk(8'h03, 3);
  endtask : finish_ir

  // Three idle rises, capture, shift n bits, update and back to idle.
  task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    walk(8'h08, 6);
    shift(n, din, dout, 1'b1);
    walk(8'h00, 1);
  endtask : scan_dr
endmodule : sbt_scan_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the test port with random rings and scan data.
// Assumes the design files and the scan model are compiled before it.
`include "sbt_defines.svh"
`default_nettype none
`define SBT_CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LEN     = `SBT_BSR_LEN_X36;
  localparam int unsigned N       = LEN + 8;
  localparam logic [10:0] VID     = 11'h35A;  // Arbitrary vendor field.
  localparam logic [31:0] ID_WORD = {`SBT_ID_REV, `SBT_ID_DEPTH, `SBT_ID_ARCH,
                                     `SBT_ID_BUS_X36, VID, `SBT_ID_PRESENT};
  logic           ref_clk_i;
  logic           rst_n_i;
  logic           tck;
  logic           tms;
  logic           tdi;
  logic           tdo;
  logic           tdo_oe;
  logic           float_o;
  logic [LEN-1:0] ring;
  logic [127:0]   din;
  logic [127:0]   dout;
  logic [127:0]   cap;
  logic [2:0]     ir_cap;
  logic           exp_f;
  logic [2:0]     codes [8] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h3, 3'h5, 3'h6, 3'h0};
  int             error_cnt;
  int             comparisons;
  int             seed;

  sbt_tap #(.BSR_LEN(LEN), .VENDOR_ID(VID)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ring_i(ring), .float_outputs_o(float_o));
  sbt_scan_model ctl (
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // Memory clock of 25 MHz.
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Bits of each shift: capture value first, then the delayed serial input.
  function automatic logic [127:0] exp_out(input int len, input logic [127:0] c,
                                           input logic [127:0] d);
    logic [127:0] r;
    for (int i = 0; i < 128; i++)
      r[i] = (i < len) ? c[i] : d[i - len];
    return r;
  endfunction : exp_out

  // Random wide word from the fixed seed.
  function automatic logic [127:0] rnd128();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction : rnd128

  // Waits a number of memory clock edges.
  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_ref

  // Scans random data through the selected register and checks the result.
  task automatic scan_dr(input int len, input logic [127:0] c);
    din = rnd128();
    ctl.scan_dr(N, din, dout);
    cap = exp_out(len, c, din);
    #10;
    `SBT_CHECK(dout[N-1:0], cap[N-1:0]);
    `SBT_CHECK(ctl.oe_after, 1'b0);
    `SBT_CHECK({tdo_oe, tdo}, 2'b00);
  endtask : scan_dr

  // Loads an instruction, checking that the float output holds until update.
  task automatic load_ir(input logic [2:0] code, input logic prev_f);
    ctl.scan_ir(code, ir_cap);
    `SBT_CHECK(ir_cap, {`SBT_IR_CAPTURE_HI, `SBT_IR_CAPTURE_LO});
    wait_ref(8);
    #1;
    `SBT_CHECK(float_o, prev_f);
    `SBT_CHECK(ctl.oe_after, 1'b0);
    ctl.finish_ir();
    wait_ref(8);
  endtask : load_ir

  // Port reset by mode select, then the identification word must come out.
  task automatic id_after_reset();
    ctl.reset_port();
    wait_ref(8);
    #1;
    `SBT_CHECK(float_o, 1'b0);
    scan_dr(32, 128'(ID_WORD));
  endtask : id_after_reset

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Cuts a hang short well after the expected run time.
  initial
  begin
    #1000000;
    error_cnt++;
    test_done();
  end

  // Main sequence: reset, every instruction code, port reset, second reset.
  initial
  begin
    error_cnt   = 0;
    comparisons = 0;
    seed        = 57293;
    rst_n_i     = 1'b0;
    ring        = '0;
    wait_ref(10);
    rst_n_i <= 1'b1;
    wait_ref(2);
    #7;
    `SBT_CHECK({tdo_oe, float_o}, 2'b00);
    id_after_reset();
    exp_f = 1'b0;
    foreach (codes[k])
    begin
      load_ir(codes[k], exp_f);
      exp_f = (codes[k] == 3'h0) || (codes[k] == 3'h2);
      `SBT_CHECK(float_o, exp_f);
      repeat (2)
      begin
        @(posedge ref_clk_i);
        ring <= LEN'(rnd128());
        wait_ref(1);
        case (codes[k])
          3'h1: scan_dr(32, 128'(ID_WORD));
          3'h0, 3'h2, 3'h4: scan_dr(LEN, 128'(ring));
          default: scan_dr(1, 128'(`SBT_BYPASS_CAPTURE));
        endcase
        `SBT_CHECK(float_o, exp_f);
      end
    end
    id_after_reset();
    load_ir(3'h2, 1'b0);
    `SBT_CHECK(float_o, 1'b1);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    wait_ref(4);
    `SBT_CHECK({tdo_oe, float_o}, 2'b00);
    rst_n_i <= 1'b1;
    wait_ref(2);
    id_after_reset();
    `SBT_CHECK(ctl.bad_cnt, 0);
    test_done();
  end
endmodule : tb
`default_nettype wire
